// ### hw/ldbm_pkg.sv
// Package: constants and types for the panel data bus mapper and its interrupts
`default_nettype none
package ldbm_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_IRQ_ENABLE  = 8'h00;
  localparam logic [7:0] OFF_IRQ_DISABLE = 8'h04;
  localparam logic [7:0] OFF_IRQ_CLEAR   = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h10;
  localparam logic [7:0] OFF_CTRL        = 8'h14;
  localparam logic [7:0] OFF_PATH_STATE  = 8'h18;

  // Control register fields
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_MODE_MSB   = 2;
  localparam int CTRL_COLOUR_BIT = 3;
  localparam int CTRL_ENABLE_BIT = 7;

  // Reset values
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [5:0]  MASK_RESET   = 6'h00;
  localparam logic [5:0]  STATUS_RESET = 6'h00;

  // Interrupt sources
  localparam int IRQ_N          = 6;
  localparam int IRQ_MEM_ERR    = 0;
  localparam int IRQ_UNDERFLOW  = 1;
  localparam int IRQ_OVERWRITE  = 2;
  localparam int IRQ_END_FRAME  = 3;
  localparam int IRQ_END_LINE   = 4;
  localparam int IRQ_END_LAST   = 5;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // STN lane widths and bits per pixel
  localparam logic [4:0] STN_NARROW  = 5'h04;
  localparam logic [4:0] STN_WIDE    = 5'h08;
  localparam logic [4:0] BITS_MONO   = 5'h01;
  localparam logic [4:0] BITS_COLOUR = 5'h03;

  typedef enum logic [2:0] {
    LDBM_STN4   = 3'h0,
    LDBM_STN8   = 3'h1,
    LDBM_DUAL8  = 3'h2,
    LDBM_DUAL16 = 3'h3,
    LDBM_TFT24  = 3'h4,
    LDBM_TFT16  = 3'h5
  } ldbm_mode_t;

  // One pixel from the serializer; STN bits are {red, green, blue}, mono uses bit 0
  typedef struct packed {
    logic [2:0]  up_bits;
    logic [2:0]  lo_bits;
    logic [23:0] tft;
  } ldbm_pix_t;

  // Event strobes from DMA, FIFO, serializer and timing generator
  typedef struct packed {
    logic mem_err;
    logic ser_rd;
    logic fifo_empty;
    logic dma_wr;
    logic fifo_full;
    logic frame_reload;
    logic line_blank_start;
    logic last_line;
    logic dma_active;
  } ldbm_evt_t;
endpackage : ldbm_pkg
`default_nettype wire

// ### hw/ldbm_top.sv
// Panel data bus mapper with six-source interrupt block and AXI4-Lite registers
// Functional notes
// - 4-bit single STN drives lines 3..0 only; lines 23..4 unused.
// - 8-bit single STN drives lines 7..0 only; lines 23..8 unused.
// - 8-bit dual STN: upper panel on 3..0, lower on 7..4.
// - 16-bit dual STN: upper panel on 7..0, lower on 15..8.
// - STN mono sends one bit per pixel, colour sends three bits.
// - STN bits leave as consecutive bits across the active lines.
// - 24-bit TFT: red 7..0, green 15..8, blue 23..16 per transfer.
// - 16-bit TFT: five bits per colour at top, intensity on 2,10,18.
// - Six interrupt sources, all made on the core clock.
// - Memory error raised on DMA bus error response.
// - Underflow raised when serializer reads an empty FIFO.
// - Overwrite raised when DMA writes a full FIFO.
// - End of frame raised when DMA reloads frame base pointers.
// - End of line raised at line blank start while DMA inactive.
// - End of last line raised at last line blank while DMA inactive.
// - Separate enable, disable and clear write registers per source.
// - Readable mask register and readable status register.
`default_nettype none
module ldbm_top (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic [1:0]                s_axi_bresp,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [7:0]           s_axi_araddr,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  input  wire logic                 pix_valid,
  output logic                      pix_ready,
  input  wire ldbm_pkg::ldbm_pix_t  pix,
  input  wire ldbm_pkg::ldbm_evt_t  evt,
  input  wire logic                 dot_clk,
  output logic [23:0]               panel_data_bus,
  output logic                      panel_data_enable,
  output logic                      irq
);

  function automatic logic [7:0] ldbm_take_bits(input logic [15:0] acc, input logic [4:0] fill,
                                                 input logic [4:0]  w);
    logic [15:0] sh;
    sh = acc >> (fill - w);
    ldbm_take_bits = (w == ldbm_pkg::STN_NARROW) ? {4'h0, sh[3:0]} : sh[7:0];
  endfunction : ldbm_take_bits
  function automatic logic [15:0] ldbm_append(input logic [15:0] acc, input logic [2:0] bits,
                                              input logic        colour);
    ldbm_append = colour ? {acc[12:0], bits} : {acc[14:0], bits[0]};
  endfunction : ldbm_append
  function automatic logic ldbm_hit(input logic [7:0] addr, input logic [7:0] off);
    ldbm_hit = ({addr[7:2], 2'b00} == off);
  endfunction : ldbm_hit
  // Registers and state
  logic [7:0]  ctrl;
  logic [5:0]  irq_mask;
  logic [5:0]  irq_status;
  logic [15:0] acc_up;
  logic [15:0] acc_lo;
  logic [4:0]  fill;
  logic [23:0] out_word;
  logic        out_full;
  logic        dot_s1;
  logic        dot_s2;
  logic        dot_s3;
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;

  // Decoded control and datapath terms
  ldbm_pkg::ldbm_mode_t mode;
  logic        enable;
  logic        colour;
  logic        is_tft;
  logic [4:0]  lane_w;
  logic [4:0]  bits_pp;
  logic        take;
  logic        emit;
  logic        dot_edge;
  logic [7:0]  up_word;
  logic [7:0]  lo_word;
  logic [23:0] stn_word;
  logic [23:0] tft_word;
  logic [4:0]  next_fill;
  logic        next_out_full;
  logic        do_write;
  logic        icr_write;
  logic [5:0]  irq_events;

  assign mode     = ldbm_pkg::ldbm_mode_t'(ctrl[ldbm_pkg::CTRL_MODE_MSB:ldbm_pkg::CTRL_MODE_LSB]);
  assign enable   = ctrl[ldbm_pkg::CTRL_ENABLE_BIT];
  assign colour   = ctrl[ldbm_pkg::CTRL_COLOUR_BIT];
  assign dot_edge = dot_s2 & ~dot_s3;
  assign take     = pix_valid & pix_ready;
  assign do_write = aw_hold & w_hold & ~s_axi_bvalid;
  assign icr_write = do_write & ldbm_hit(wr_addr, ldbm_pkg::OFF_IRQ_CLEAR) & wr_strb[0];

  // Datapath steering per panel mode
  always_comb begin
    is_tft   = (mode == ldbm_pkg::LDBM_TFT24) | (mode == ldbm_pkg::LDBM_TFT16);
    lane_w   = ((mode == ldbm_pkg::LDBM_STN8) | (mode == ldbm_pkg::LDBM_DUAL16)) ?
               ldbm_pkg::STN_WIDE : ldbm_pkg::STN_NARROW;
    bits_pp  = colour ? ldbm_pkg::BITS_COLOUR : ldbm_pkg::BITS_MONO;
    emit     = enable & ~is_tft & ~out_full & (fill >= lane_w);
    up_word  = ldbm_take_bits(acc_up, fill, lane_w);
    lo_word  = ldbm_take_bits(acc_lo, fill, lane_w);
    stn_word = 24'h000000;
    case (mode)
      ldbm_pkg::LDBM_STN4:   stn_word[3:0]  = up_word[3:0];
      ldbm_pkg::LDBM_STN8:   stn_word[7:0]  = up_word;
      ldbm_pkg::LDBM_DUAL8:  stn_word[7:0]  = {lo_word[3:0], up_word[3:0]};
      ldbm_pkg::LDBM_DUAL16: stn_word[15:0] = {lo_word, up_word};
      default:               stn_word       = 24'h000000;
    endcase
    tft_word = 24'h000000;
    case (mode)
      ldbm_pkg::LDBM_TFT24: tft_word = pix.tft;
      ldbm_pkg::LDBM_TFT16: tft_word = {pix.tft[14:10], pix.tft[15], 2'b00,
                                        pix.tft[9:5], pix.tft[15], 2'b00,
                                        pix.tft[4:0], pix.tft[15], 2'b00};
      default:              tft_word = 24'h000000;
    endcase
    next_fill     = (emit ? fill - lane_w : fill) + (take & ~is_tft ? bits_pp : 5'h00);
    next_out_full = emit | (take & is_tft) | (out_full & ~dot_edge);
  end

  // Dot clock sampling
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dot_s1 <= 1'b0;
      dot_s2 <= 1'b0;
      dot_s3 <= 1'b0;
    end else begin
      dot_s1 <= dot_clk;
      dot_s2 <= dot_s1;
      dot_s3 <= dot_s2;
    end
  end

  // STN bit packer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_up <= 16'h0000;
      acc_lo <= 16'h0000;
      fill   <= 5'h00;
    end else if (!enable) begin
      fill   <= 5'h00;
    end else begin
      fill <= next_fill;
      if (take && !is_tft) begin
        acc_up <= ldbm_append(acc_up, pix.up_bits, colour);
        acc_lo <= ldbm_append(acc_lo, pix.lo_bits, colour);
      end
    end
  end

  // Output slot and input readiness
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_word  <= 24'h000000;
      out_full  <= 1'b0;
      pix_ready <= 1'b0;
    end else if (!enable) begin
      out_full  <= 1'b0;
      pix_ready <= 1'b0;
    end else begin
      out_full  <= next_out_full;
      pix_ready <= is_tft ? ~next_out_full : (next_fill < lane_w);
      if (emit) begin
        out_word <= stn_word;
      end else if (take && is_tft) begin
        out_word <= tft_word;
      end
    end
  end

  // Panel bus drive on each dot clock rising edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      panel_data_bus    <= 24'h000000;
      panel_data_enable <= 1'b0;
    end else if (!enable) begin
      panel_data_bus    <= 24'h000000;
      panel_data_enable <= 1'b0;
    end else if (dot_edge) begin
      panel_data_enable <= out_full;
      if (out_full) begin
        panel_data_bus <= out_word;
      end
    end
  end

  // Interrupt sources on the core clock
  always_comb begin
    irq_events = 6'h00;
    irq_events[ldbm_pkg::IRQ_MEM_ERR]   = evt.mem_err;
    irq_events[ldbm_pkg::IRQ_UNDERFLOW] = evt.ser_rd & evt.fifo_empty;
    irq_events[ldbm_pkg::IRQ_OVERWRITE] = evt.dma_wr & evt.fifo_full;
    irq_events[ldbm_pkg::IRQ_END_FRAME] = evt.frame_reload;
    irq_events[ldbm_pkg::IRQ_END_LINE]  = evt.line_blank_start & ~evt.dma_active;
    irq_events[ldbm_pkg::IRQ_END_LAST]  = evt.line_blank_start & evt.last_line &
                                          ~evt.dma_active;
  end

  // Status, mask and control registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_status <= ldbm_pkg::STATUS_RESET;
      irq_mask   <= ldbm_pkg::MASK_RESET;
      ctrl       <= ldbm_pkg::CTRL_RESET;
      irq        <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~(icr_write ? wr_data[5:0] : 6'h00)) | irq_events;
      irq        <= |(irq_status & irq_mask);
      if (do_write && wr_strb[0]) begin
        if (ldbm_hit(wr_addr, ldbm_pkg::OFF_IRQ_ENABLE)) begin
          irq_mask <= irq_mask | wr_data[5:0];
        end else if (ldbm_hit(wr_addr, ldbm_pkg::OFF_IRQ_DISABLE)) begin
          irq_mask <= irq_mask & ~wr_data[5:0];
        end else if (ldbm_hit(wr_addr, ldbm_pkg::OFF_CTRL)) begin
          ctrl <= wr_data[7:0];
        end
      end
    end
  end

  // AXI4-Lite write channel
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ldbm_pkg::RESP_OKAY;
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      wr_addr       <= 8'h00;
      wr_data       <= 32'h00000000;
      wr_strb       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_hold       <= 1'b1;
        wr_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_hold       <= 1'b1;
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (ldbm_hit(wr_addr, ldbm_pkg::OFF_IRQ_ENABLE) ||
                         ldbm_hit(wr_addr, ldbm_pkg::OFF_IRQ_DISABLE) ||
                         ldbm_hit(wr_addr, ldbm_pkg::OFF_IRQ_CLEAR) ||
                         ldbm_hit(wr_addr, ldbm_pkg::OFF_CTRL)) ?
                        ldbm_pkg::RESP_OKAY : ldbm_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= ldbm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= ldbm_pkg::RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      if (ldbm_hit(s_axi_araddr, ldbm_pkg::OFF_IRQ_MASK)) begin
        s_axi_rdata[5:0] <= irq_mask;
      end else if (ldbm_hit(s_axi_araddr, ldbm_pkg::OFF_IRQ_STATUS)) begin
        s_axi_rdata[5:0] <= irq_status;
      end else if (ldbm_hit(s_axi_araddr, ldbm_pkg::OFF_CTRL)) begin
        s_axi_rdata[7:0] <= ctrl;
      end else if (ldbm_hit(s_axi_araddr, ldbm_pkg::OFF_PATH_STATE)) begin
        s_axi_rdata[5:0] <= {out_full, fill};
      end else if (!ldbm_hit(s_axi_araddr, ldbm_pkg::OFF_IRQ_ENABLE) &&
                   !ldbm_hit(s_axi_araddr, ldbm_pkg::OFF_IRQ_DISABLE) &&
                   !ldbm_hit(s_axi_araddr, ldbm_pkg::OFF_IRQ_CLEAR)) begin
        s_axi_rresp <= ldbm_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Checks
  default clocking ldbm_cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence seq_slot_drain;
    enable && dot_edge && out_full;
  endsequence
  sequence seq_stn_colour_take;
    take && !is_tft && colour && !emit;
  endsequence
  AST_STN4_UPPER_LOW: assert property (
    emit && mode == ldbm_pkg::LDBM_STN4 |=> out_word[23:4] == 20'h00000)
    else $error("STN4 upper lines not low");
  AST_STN8_UPPER_LOW: assert property (
    emit && mode == ldbm_pkg::LDBM_STN8 |=> out_word[23:8] == 16'h0000)
    else $error("STN8 upper lines not low");
  AST_DUAL8_LANES: assert property (
    emit && mode == ldbm_pkg::LDBM_DUAL8 |=> out_word[3:0] == $past(up_word[3:0]) &&
    out_word[7:4] == $past(lo_word[3:0]) && out_word[23:8] == 16'h0000)
    else $error("Dual 8 lane placement wrong");
  AST_DUAL16_LANES: assert property (
    emit && mode == ldbm_pkg::LDBM_DUAL16 |=> out_word[7:0] == $past(up_word) &&
    out_word[15:8] == $past(lo_word) && out_word[23:16] == 8'h00)
    else $error("Dual 16 lane placement wrong");
  AST_COLOUR_THREE_BITS: assert property (
    seq_stn_colour_take ##0 enable |=> fill == $past(fill) + 5'h03)
    else $error("Colour pixel did not add three bits");
  AST_BUS_FROM_SLOT: assert property (
    seq_slot_drain |=> panel_data_enable && panel_data_bus == $past(out_word) &&
    !out_full ##1 (panel_data_enable || !enable))
    else $error("Panel bus did not take the slot word");
  AST_TFT24_LANES: assert property (
    take && mode == ldbm_pkg::LDBM_TFT24 |=> out_word[7:0] == $past(pix.tft[7:0]) &&
    out_word[23:16] == $past(pix.tft[23:16]) && out_full)
    else $error("TFT24 component placement wrong");
  AST_TFT16_INTENSITY: assert property (
    take && mode == ldbm_pkg::LDBM_TFT16 |=> out_word[2] == $past(pix.tft[15]) &&
    out_word[10] == out_word[2] && out_word[18] == out_word[2] &&
    out_word[7:3] == $past(pix.tft[4:0]) && out_word[1:0] == 2'b00)
    else $error("TFT16 placement wrong");
  AST_UNDERFLOW_SET: assert property (
    evt.ser_rd && evt.fifo_empty |=> irq_status[ldbm_pkg::IRQ_UNDERFLOW])
    else $error("Underflow not flagged");
  AST_END_LINE_SET: assert property (
    evt.line_blank_start && !evt.dma_active |=> irq_status[ldbm_pkg::IRQ_END_LINE])
    else $error("End of line not flagged");
  AST_STATUS_STICKY: assert property (
    !icr_write |=> (irq_status & $past(irq_status)) == $past(irq_status))
    else $error("Status bit dropped without a clear");
  AST_IRQ_OUT: assert property (
    (irq_status & irq_mask) != 6'h00 |=> irq ##1 (irq || $past(irq_status & irq_mask) == 6'h00))
    else $error("Interrupt output missing");

endmodule : ldbm_top
`default_nettype wire

// ### test/ldbm_panel_model.sv
// Panel driver model: captures the words it is shown on its dot clock
`default_nettype none
module ldbm_panel_model #(
  parameter int COMP_BITS = 8
) (
  input wire logic        dot_clk,
  input wire logic [23:0] panel_data_bus,
  input wire logic        panel_data_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  comp_mask;
  logic [23:0] words[$];
  // A narrower panel is wired to the top bits of each component byte
  assign comp_mask = 8'hff << (8 - COMP_BITS);
  // A word launched after one dot edge is settled by the next one
  always @(posedge dot_clk) begin
    if (panel_data_enable === 1'b1) begin
      words.push_back(panel_data_bus & {3{comp_mask}});
    end
  end
endmodule : ldbm_panel_model
`default_nettype wire

// ### test/tb_ldbm_top.sv
// Self-checking testbench for the panel data bus mapper and its interrupt block
`default_nettype none
module tb_ldbm_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk, rst_b, dot_clk, dot_run;
  logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                s_axi_rvalid, s_axi_rready, pix_valid, pix_ready;
  logic                panel_data_enable, irq;
  logic [7:0]          s_axi_awaddr, s_axi_araddr;
  logic [31:0]         s_axi_wdata, s_axi_rdata;
  logic [3:0]          s_axi_wstrb;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  logic [23:0]         panel_data_bus;
  ldbm_pkg::ldbm_pix_t pix;
  ldbm_pkg::ldbm_evt_t evt;
  logic [23:0]         exp_q[$];
  int                  fails, n_compared, n_cycles;
  // Event vectors in struct order and the status bits each one should set
  logic [8:0] ev_tab[10] = '{9'h100, 9'h080, 9'h0c0, 9'h050, 9'h030, 9'h008, 9'h005, 9'h004,
                             9'h007, 9'h006};
  logic [5:0] st_tab[10] = '{6'h01, 6'h00, 6'h02, 6'h00, 6'h04, 6'h08, 6'h00, 6'h10, 6'h00,
                             6'h30};

  ldbm_top u_ldbm_top (
    .clk(clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .pix(pix), .evt(evt), .dot_clk(dot_clk),
    .panel_data_bus(panel_data_bus), .panel_data_enable(panel_data_enable), .irq(irq)
  );

  ldbm_panel_model u_ldbm_panel_model (
    .dot_clk(dot_clk), .panel_data_bus(panel_data_bus), .panel_data_enable(panel_data_enable)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Dot clock runs only while a frame is being sent
  initial begin
    dot_clk = 1'b0;
    #7;
    forever begin
      #100;
      if (dot_run || dot_clk) dot_clk = ~dot_clk;
    end
  end

  always @(posedge clk) begin
    n_cycles = n_cycles + 1;
    if (n_cycles == 20000) begin
      fails = fails + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
                        input logic [1:0] er);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, er);
    @(posedge clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, ed);
    check(s_axi_rresp, er);
    @(posedge clk);
  endtask : axi_rd

  function automatic ldbm_pkg::ldbm_pix_t pix_of(input int i);
    return '{3'(i * 3 + 1), 3'(i * 5 + 6), 24'(i * 24'h1f3c57 + 24'ha50f81)};
  endfunction : pix_of

  // Builds the words the panel should see for n pixels in mode m
  task automatic expect_words(input logic [2:0] m, input logic c, input int n);
    logic                up_q[$];
    logic                lo_q[$];
    logic [23:0]         w;
    ldbm_pkg::ldbm_pix_t p;
    int                  lw;
    exp_q = {};
    lw = (m == 3'h0 || m == 3'h2) ? 4 : 8;
    for (int i = 0; i < n; i++) begin
      p = pix_of(i);
      if (m == 3'h4) begin
        exp_q.push_back(p.tft);
      end else if (m == 3'h5) begin
        exp_q.push_back({p.tft[14:10], p.tft[15], 2'h0, p.tft[9:5], p.tft[15], 2'h0,
                         p.tft[4:0], p.tft[15], 2'h0});
      end else begin
        for (int b = 2; b >= 0; b--) begin
          if (c || b == 0) begin
            up_q.push_back(p.up_bits[b]);
            lo_q.push_back(p.lo_bits[b]);
          end
        end
        if (up_q.size() >= lw) begin
          w = 24'h0;
          for (int k = lw - 1; k >= 0; k--) begin
            w[k] = up_q.pop_front();
            if (m >= 3'h2) w[k + lw] = lo_q.pop_front();
          end
          exp_q.push_back(w);
        end
      end
    end
  endtask : expect_words

  task automatic send_pixels(input int n);
    pix_valid <= 1'b1;
    for (int i = 0; i < n; i++) begin
      pix <= pix_of(i);
      do @(posedge clk); while (pix_ready !== 1'b1);
    end
    pix_valid <= 1'b0;
    @(posedge clk);
  endtask : send_pixels

  task automatic run_mode(input logic [2:0] m, input logic c);
    logic [31:0] cw;
    cw = {24'h0, 1'b1, 3'h0, c, m};
    axi_wr(ldbm_pkg::OFF_CTRL, 32'h0, 4'hf, ldbm_pkg::RESP_OKAY);
    axi_wr(ldbm_pkg::OFF_CTRL, cw, 4'hf, ldbm_pkg::RESP_OKAY);
    axi_rd(ldbm_pkg::OFF_CTRL, cw, ldbm_pkg::RESP_OKAY);
    expect_words(m, c, 16);
    u_ldbm_panel_model.words.delete();
    dot_run = 1'b1;
    send_pixels(16);
    while (u_ldbm_panel_model.words.size() < exp_q.size()) @(posedge clk);
    repeat (24) @(posedge clk);
    dot_run = 1'b0;
    check(u_ldbm_panel_model.words.size(), exp_q.size());
    foreach (exp_q[k]) check(u_ldbm_panel_model.words[k], exp_q[k]);
  endtask : run_mode

  // Mask holds sources 0 and 4 while each event is fired
  task automatic fire(input logic [8:0] e, input logic [5:0] es);
    evt <= e;
    @(posedge clk);
    evt <= '0;
    repeat (3) @(posedge clk);
    check(irq, |(es & 6'h11));
    axi_rd(ldbm_pkg::OFF_IRQ_STATUS, {26'h0, es}, ldbm_pkg::RESP_OKAY);
    if (es != 6'h00) begin
      axi_wr(ldbm_pkg::OFF_IRQ_CLEAR, {26'h0, es}, 4'hf, ldbm_pkg::RESP_OKAY);
      axi_rd(ldbm_pkg::OFF_IRQ_STATUS, 32'h0, ldbm_pkg::RESP_OKAY);
      check(irq, 1'b0);
    end
  endtask : fire

  initial begin
    rst_b = 1'b0;
    dot_run = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    pix_valid = 1'b0;
    pix = '0;
    evt = '0;
    fails = 0;
    n_compared = 0;
    n_cycles = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    axi_rd(ldbm_pkg::OFF_IRQ_MASK, {26'h0, ldbm_pkg::MASK_RESET}, ldbm_pkg::RESP_OKAY);
    axi_rd(ldbm_pkg::OFF_IRQ_STATUS, {26'h0, ldbm_pkg::STATUS_RESET}, 2'h0);
    axi_rd(ldbm_pkg::OFF_CTRL, {24'h0, ldbm_pkg::CTRL_RESET}, ldbm_pkg::RESP_OKAY);
    axi_rd(8'h1c, 32'h0, ldbm_pkg::RESP_SLVERR);
    axi_rd(ldbm_pkg::OFF_PATH_STATE, 32'h0, ldbm_pkg::RESP_OKAY);
    axi_rd(ldbm_pkg::OFF_IRQ_ENABLE, 32'h0, ldbm_pkg::RESP_OKAY);
    axi_wr(ldbm_pkg::OFF_IRQ_MASK, 32'h3f, 4'hf, ldbm_pkg::RESP_SLVERR);
    axi_wr(ldbm_pkg::OFF_CTRL, 32'h85, 4'h0, ldbm_pkg::RESP_OKAY);
    axi_rd(ldbm_pkg::OFF_CTRL, 32'h0, ldbm_pkg::RESP_OKAY);
    axi_wr(ldbm_pkg::OFF_IRQ_ENABLE, 32'h15, 4'hf, ldbm_pkg::RESP_OKAY);
    axi_rd(ldbm_pkg::OFF_IRQ_MASK, 32'h15, ldbm_pkg::RESP_OKAY);
    axi_wr(ldbm_pkg::OFF_IRQ_DISABLE, 32'h04, 4'hf, ldbm_pkg::RESP_OKAY);
    axi_rd(ldbm_pkg::OFF_IRQ_MASK, 32'h11, ldbm_pkg::RESP_OKAY);
    for (int k = 0; k < 10; k++) fire(ev_tab[k], st_tab[k]);
    for (int m = 0; m < 6; m++) begin
      for (int c = 0; c < 2; c++) run_mode(3'(m), 1'(c));
    end
    print_verdict();
  end
endmodule : tb_ldbm_top
`default_nettype wire
